//--- core/kms_scanner.sv
`timescale 1ns/100ps
module kms_scanner #(
  parameter int unsigned SCAN_GAP = kms_pkg::SCAN_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            resetn,
  // Key matrix
  output logic      [kms_pkg::DRIVE_LINES-1:0] scan_drive_line,
  input  wire logic [kms_pkg::SENSE_LINES-1:0] scan_sense_line,
  // Static configuration
  input  wire logic [kms_pkg::KEY_SLOTS-1:0]   key_fitted,
  input  wire logic [7:0]                      settle_cycles,
  // System power
  input  wire logic                            sys_idle,
  output logic                                 low_power_ok,
  output logic                                 key_wake,
  output logic                                 polling_active,
  // Key events to the reporting layer
  output logic                                 evt_valid,
  output logic                                 evt_press,
  output logic      [kms_pkg::DRV_W-1:0]       evt_drive,
  output logic      [kms_pkg::SNS_W-1:0]       evt_sense
);
  import kms_pkg::*;

  kms_state_t                state_reg;
  logic [DRIVE_LINES-1:0]    drive_reg;
  logic [DRV_W-1:0]          row_reg;
  logic [CNT_W-1:0]          cnt_reg;
  logic [SENSE_LINES-1:0]    sns_meta_reg;
  logic [SENSE_LINES-1:0]    sns_sync_reg;
  logic [KEY_SLOTS-1:0]      raw_reg; // One bit per crossing
  logic [KEY_SLOTS-1:0]      rep_reg;
  logic [KEY_SLOTS-1:0]      clean_keys;
  logic [KEY_SLOTS-1:0]      diff;
  logic [IDX_W-1:0]          diff_idx;
  logic [3:0]                idle_cnt_reg;
  logic [CNT_W-1:0]          settle_target;
  logic                      wake_reg;
  logic                      evt_valid_reg;
  logic                      evt_press_reg;
  logic [DRV_W-1:0]          evt_drive_reg;
  logic [SNS_W-1:0]          evt_sense_reg;

  // Lowest differing key position
  function automatic logic [IDX_W-1:0] first_set(input logic [KEY_SLOTS-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = KEY_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // One drive line pulled low, all others driven high
  function automatic logic [DRIVE_LINES-1:0] drive_one(input logic [DRV_W-1:0] row);
    logic [DRIVE_LINES-1:0] d;
    d = DRIVE_ALL_OFF;
    d[row] = 1'b0;
    return d;
  endfunction

  // Sense pins arrive from the matrix asynchronously
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sns_meta_reg <= SENSE_IDLE;
      sns_sync_reg <= SENSE_IDLE;
    end else begin
      sns_meta_reg <= scan_sense_line;
      sns_sync_reg <= sns_meta_reg;
    end
  end

  kms_ghost u_ghost (
    .raw_keys   (raw_reg),
    .key_fitted (key_fitted),
    .clean_keys (clean_keys)
  );

  // Zero settle still waits one cycle, plus synchroniser delay
  assign settle_target = CNT_W'(settle_cycles) + CNT_W'(SYNC_LAT)
                       + ((settle_cycles == 8'h00) ? CNT_W'(1) : CNT_W'(0));
  assign diff          = clean_keys ^ rep_reg;
  assign diff_idx      = first_set(diff);

  // Scan sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= KMS_ARM;
      drive_reg    <= DRIVE_ALL_ON;
      row_reg      <= '0;
      cnt_reg      <= '0;
      idle_cnt_reg <= '0;
      wake_reg     <= 1'b0;
    end else begin
      wake_reg <= 1'b0;
      case (state_reg)
        KMS_ARM: begin
          drive_reg <= DRIVE_ALL_ON;
          if (cnt_reg + CNT_W'(1) >= settle_target) begin
            cnt_reg   <= '0;
            state_reg <= KMS_IRQ;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        KMS_IRQ: begin
          // Only a level change is seen, so no key identity is kept
          if (sns_sync_reg != SENSE_IDLE) begin
            wake_reg  <= 1'b1;
            row_reg   <= '0;
            drive_reg <= drive_one('0);
            state_reg <= KMS_SETTLE;
          end
        end
        KMS_SETTLE: begin
          if (cnt_reg + CNT_W'(1) >= settle_target) begin
            cnt_reg   <= '0;
            state_reg <= KMS_SAMPLE;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        KMS_SAMPLE: begin
          if (row_reg == DRV_W'(DRIVE_LINES - 1)) begin
            drive_reg <= DRIVE_ALL_OFF;
            state_reg <= KMS_EMIT;
          end else begin
            row_reg   <= row_reg + DRV_W'(1);
            drive_reg <= drive_one(row_reg + DRV_W'(1));
            state_reg <= KMS_SETTLE;
          end
        end
        KMS_EMIT: begin
          if (diff == '0) begin
            if (clean_keys != '0) begin
              idle_cnt_reg <= '0;
              state_reg    <= KMS_GAP;
            end else if (idle_cnt_reg + 4'h1 >= 4'(IDLE_SCANS)) begin
              // Nothing held: rearm now, so the arm wait covers the drive change
              idle_cnt_reg <= '0;
              drive_reg    <= DRIVE_ALL_ON;
              state_reg    <= KMS_ARM;
            end else begin
              idle_cnt_reg <= idle_cnt_reg + 4'h1;
              state_reg    <= KMS_GAP;
            end
          end
        end
        KMS_GAP: begin
          if (cnt_reg + CNT_W'(1) >= CNT_W'(SCAN_GAP)) begin
            cnt_reg   <= '0;
            row_reg   <= '0;
            drive_reg <= drive_one('0);
            state_reg <= KMS_SETTLE;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        default: begin
          cnt_reg   <= '0;
          drive_reg <= DRIVE_ALL_ON;
          state_reg <= KMS_ARM;
        end
      endcase
    end
  end

  // Capture one drive line worth of sense bits per sample
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      raw_reg <= '0;
    end else if (state_reg == KMS_IRQ && sns_sync_reg != SENSE_IDLE) begin
      raw_reg <= '0;
    end else if (state_reg == KMS_SAMPLE) begin
      // Low sense bit is a closed key at this crossing
      raw_reg[kms_key_idx(int'(row_reg), 0) +: SENSE_LINES] <= ~sns_sync_reg;
    end
  end

  // One event per cycle until reported set matches the scan
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rep_reg       <= '0;
      evt_valid_reg <= 1'b0;
      evt_press_reg <= 1'b0;
      evt_drive_reg <= '0;
      evt_sense_reg <= '0;
    end else begin
      evt_valid_reg <= 1'b0;
      if (state_reg == KMS_EMIT && diff != '0) begin
        rep_reg[diff_idx] <= clean_keys[diff_idx];
        evt_valid_reg     <= 1'b1;
        evt_press_reg     <= clean_keys[diff_idx];
        evt_drive_reg     <= diff_idx[IDX_W-1:SNS_W];
        evt_sense_reg     <= diff_idx[SNS_W-1:0];
      end
    end
  end

  // Outputs
  assign scan_drive_line = drive_reg;
  assign key_wake        = wake_reg;
  assign low_power_ok    = (state_reg == KMS_IRQ) && sys_idle;
  assign polling_active  = (state_reg != KMS_ARM) && (state_reg != KMS_IRQ);
  assign evt_valid       = evt_valid_reg;
  assign evt_press       = evt_press_reg;
  assign evt_drive       = evt_drive_reg;
  assign evt_sense       = evt_sense_reg;

endmodule

//--- core/kms_pkg.sv
package kms_pkg;

  // Matrix geometry
  localparam int DRIVE_LINES = 15;
  localparam int SENSE_LINES = 8;
  localparam int KEY_SLOTS   = DRIVE_LINES * SENSE_LINES;
  localparam int FITTED_KEYS = 84;
  localparam int DRV_W       = 4;
  localparam int SNS_W       = 3;
  localparam int IDX_W       = 7;

  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int SCAN_GAP_US     = 1000;
  localparam int SCAN_GAP_CYCLES = (CLK_HZ / 1_000_000) * SCAN_GAP_US;
  localparam int CNT_W           = 16;
  localparam int SYNC_LAT        = 2;
  localparam int IDLE_SCANS      = 4;

  // Drive and sense line levels
  localparam logic [DRIVE_LINES-1:0] DRIVE_ALL_ON  = 15'h0000;
  localparam logic [DRIVE_LINES-1:0] DRIVE_ALL_OFF = 15'h7fff;
  localparam logic [SENSE_LINES-1:0] SENSE_IDLE    = 8'hff;

  typedef enum logic [2:0] {
    KMS_ARM    = 3'b000,
    KMS_IRQ    = 3'b001,
    KMS_SETTLE = 3'b010,
    KMS_SAMPLE = 3'b011,
    KMS_EMIT   = 3'b100,
    KMS_GAP    = 3'b101
  } kms_state_t;

  // Flat key position from drive and sense index
  function automatic int kms_key_idx(input int drv, input int sns);
    return drv * SENSE_LINES + sns;
  endfunction

endpackage

//--- core/kms_ghost.sv
`timescale 1ns/100ps
module kms_ghost (
  // Scan result and fitted map
  input  wire logic [kms_pkg::KEY_SLOTS-1:0] raw_keys,
  input  wire logic [kms_pkg::KEY_SLOTS-1:0] key_fitted,
  // Filtered key set
  output logic      [kms_pkg::KEY_SLOTS-1:0] clean_keys
);
  import kms_pkg::*;

  logic [KEY_SLOTS-1:0] suspect;

  // Rectangle search over every pair of drive and sense lines
  always_comb begin
    int a;
    int b;
    int c;
    int d;
    int hits;
    suspect = '0;
    a = 0;
    b = 0;
    c = 0;
    d = 0;
    hits = 0;
    for (int r1 = 0; r1 < DRIVE_LINES; r1++) begin
      for (int r2 = r1 + 1; r2 < DRIVE_LINES; r2++) begin
        for (int c1 = 0; c1 < SENSE_LINES; c1++) begin
          for (int c2 = c1 + 1; c2 < SENSE_LINES; c2++) begin
            a = kms_key_idx(r1, c1);
            b = kms_key_idx(r1, c2);
            c = kms_key_idx(r2, c1);
            d = kms_key_idx(r2, c2);
            hits = int'(raw_keys[a]) + int'(raw_keys[b]) + int'(raw_keys[c])
                 + int'(raw_keys[d]);
            // Unfitted corner cannot close a false path
            if (hits >= 3 && key_fitted[a] && key_fitted[b] && key_fitted[c]
                && key_fitted[d]) begin
              suspect[a] = suspect[a] | raw_keys[a];
              suspect[b] = suspect[b] | raw_keys[b];
              suspect[c] = suspect[c] | raw_keys[c];
              suspect[d] = suspect[d] | raw_keys[d];
            end
          end
        end
      end
    end
    // Whole rectangle withheld: which corner is false cannot be told
    clean_keys = raw_keys & key_fitted & ~suspect;
  end

endmodule

//--- test/kms_scanner_properties.sv
`timescale 1ns/100ps
module kms_scanner_checker #(
  parameter int unsigned SCAN_GAP = 20
) (
  // Clock and reset
  input wire logic                            core_clk,
  input wire logic                            resetn,
  // Key matrix
  input wire logic [kms_pkg::DRIVE_LINES-1:0] scan_drive_line,
  input wire logic [kms_pkg::SENSE_LINES-1:0] scan_sense_line,
  // Configuration and power
  input wire logic [kms_pkg::KEY_SLOTS-1:0]   key_fitted,
  input wire logic [7:0]                      settle_cycles,
  input wire logic                            sys_idle,
  input wire logic                            low_power_ok,
  input wire logic                            key_wake,
  input wire logic                            polling_active,
  // Key events
  input wire logic                            evt_valid,
  input wire logic                            evt_press,
  input wire logic [kms_pkg::DRV_W-1:0]       evt_drive,
  input wire logic [kms_pkg::SNS_W-1:0]       evt_sense
);
  import kms_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] hist_reg;
  // Recent non-idle sense samples; deep enough to span the sync delay
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) hist_reg <= 4'h0;
    else hist_reg <= {hist_reg[2:0], scan_sense_line != SENSE_IDLE};
  end
  logic [DRIVE_LINES-1:0] drv_prev_reg;
  logic [9:0]             hold_reg;
  // Cycles the present drive pattern has stood; wraps harmlessly while armed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drv_prev_reg <= DRIVE_ALL_ON;
      hold_reg     <= 10'h000;
    end else begin
      drv_prev_reg <= scan_drive_line;
      hold_reg     <= (scan_drive_line != drv_prev_reg) ? 10'h001 : hold_reg + 10'h001;
    end
  end
  AST_ROW_HOLD: assert property (polling_active && $past(polling_active)
    && $changed(scan_drive_line) && $past(scan_drive_line) != DRIVE_ALL_OFF
    |-> hold_reg == 10'(settle_cycles) + 10'(SYNC_LAT + 1)
      + ((settle_cycles == 8'h00) ? 10'h001 : 10'h000))
    else $error("row held a wrong number of cycles");
  AST_IRQ_ALL_ON: assert property (!polling_active |-> scan_drive_line == DRIVE_ALL_ON)
    else $error("drive not all on outside polling");
  AST_POLL_ONE: assert property (polling_active |-> scan_drive_line == DRIVE_ALL_OFF
    || $onehot(~scan_drive_line)) else $error("more than one drive low");
  AST_ROW_STEP: assert property (polling_active && $past(polling_active)
    && $changed(scan_drive_line) && $past(scan_drive_line) != DRIVE_ALL_OFF
    && scan_drive_line != DRIVE_ALL_OFF
    |-> scan_drive_line == (($past(scan_drive_line) << 1) | 15'h0001))
    else $error("rows out of order");
  AST_SETTLE: assert property (polling_active && $changed(scan_drive_line)
    && scan_drive_line != DRIVE_ALL_OFF |=> $stable(scan_drive_line)[*2])
    else $error("row left before settling");
  AST_LOW_POWER: assert property (low_power_ok |-> sys_idle && !polling_active)
    else $error("sleep allowed outside armed idle");
  AST_WAKE_CAUSE: assert property (key_wake |-> hist_reg != 4'h0)
    else $error("wake without sense activity");
  AST_WAKE_POLL: assert property (key_wake |-> polling_active
    && scan_drive_line == 15'h7ffe) else $error("wake not followed by row 0");
  AST_WAKE_PULSE: assert property (key_wake |=> !key_wake)
    else $error("wake longer than a pulse");
  AST_EVT_EMIT: assert property (evt_valid |-> scan_drive_line == DRIVE_ALL_OFF)
    else $error("event during sampling");
  AST_EVT_FITTED: assert property (evt_valid |-> key_fitted[{evt_drive, evt_sense}])
    else $error("event on unfitted key");
  COV_WAKE: cover property (key_wake);
  COV_PRESS: cover property (evt_valid && evt_press);
  COV_RELEASE: cover property (evt_valid && !evt_press);
  COV_SLEEP: cover property (low_power_ok);
endmodule
bind kms_scanner kms_scanner_checker #(.SCAN_GAP(SCAN_GAP)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .scan_drive_line(scan_drive_line),
  .scan_sense_line(scan_sense_line), .key_fitted(key_fitted), .settle_cycles(settle_cycles),
  .sys_idle(sys_idle), .low_power_ok(low_power_ok), .key_wake(key_wake),
  .polling_active(polling_active), .evt_valid(evt_valid), .evt_press(evt_press),
  .evt_drive(evt_drive), .evt_sense(evt_sense));

//--- test/kms_key_matrix.sv
`timescale 1ns/100ps
module kms_key_matrix (
  // Switch states and drive pins
  input wire logic [kms_pkg::KEY_SLOTS-1:0]   pressed,
  input wire logic [kms_pkg::DRIVE_LINES-1:0] scan_drive_line,
  // Sense pins
  output logic     [kms_pkg::SENSE_LINES-1:0] scan_sense_line
);
  import kms_pkg::*;
  // Pull-up holds high unless a closed switch meets a low drive
  always_comb begin
    scan_sense_line = SENSE_IDLE;
    for (int d = 0; d < DRIVE_LINES; d++)
      for (int s = 0; s < SENSE_LINES; s++)
        if (pressed[d*SENSE_LINES+s] && !scan_drive_line[d]) scan_sense_line[s] = 1'b0;
  end
endmodule

//--- test/test_kms_scanner.sv
`timescale 1ns/100ps
module test_kms_scanner;
  import kms_pkg::*;
  logic                   core_clk, resetn, sys_idle;
  logic                   low_power_ok, key_wake, polling_active, evt_valid, evt_press;
  logic [DRIVE_LINES-1:0] scan_drive_line;
  logic [SENSE_LINES-1:0] scan_sense_line;
  logic [KEY_SLOTS-1:0]   key_fitted, pressed;
  logic [DRV_W-1:0]       evt_drive;
  logic [SNS_W-1:0]       evt_sense;
  logic [7:0]             settle;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  kms_scanner #(.SCAN_GAP(20)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .scan_drive_line(scan_drive_line),
    .scan_sense_line(scan_sense_line), .key_fitted(key_fitted), .settle_cycles(settle),
    .sys_idle(sys_idle), .low_power_ok(low_power_ok), .key_wake(key_wake),
    .polling_active(polling_active), .evt_valid(evt_valid), .evt_press(evt_press),
    .evt_drive(evt_drive), .evt_sense(evt_sense));
  kms_key_matrix u_mat (.pressed(pressed), .scan_drive_line(scan_drive_line),
    .scan_sense_line(scan_sense_line));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(logic ok, string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait for a flag; running out ends the run
  task automatic wait_on(ref logic sig, input int lim, input string what);
    int i;
    for (i = 0; i < lim && sig !== 1'b1; i++) tick();
    if (sig !== 1'b1) begin
      check(1'b0, what);
      wrap_up();
    end
  endtask
  // Events come back to back, so one per cycle is taken
  task automatic get_evt(logic prs, int d, int s);
    wait_on(evt_valid, 3000, "no event");
    check(evt_press === prs && evt_drive === DRV_W'(d) && evt_sense === SNS_W'(s), "event");
    tick();
  endtask
  task automatic t_single();
    wait_on(low_power_ok, 1500, "no sleep");
    check(scan_drive_line === DRIVE_ALL_ON, "sleep drive");
    pressed[7*8+3] = 1'b1;
    wait_on(key_wake, 10, "no wake");
    check(polling_active === 1'b1 && scan_drive_line === 15'h7ffe, "wake poll");
    get_evt(1'b1, 7, 3);
    pressed[7*8+3] = 1'b0;
    get_evt(1'b0, 7, 3);
    $display("single key test done");
  endtask
  task automatic t_ghost();
    int n;
    n = 0;
    wait_on(low_power_ok, 1500, "no sleep");
    pressed[9] = 1'b1;
    pressed[10] = 1'b1;
    pressed[17] = 1'b1;
    repeat (400) begin
      tick();
      if (evt_valid === 1'b1) n++;
    end
    check(n == 0, "ghost reported");
    pressed = '0;
    $display("ghost test done");
  endtask
  // Fourth corner (10,4) is unfitted, so all three keys count
  task automatic t_unfit();
    wait_on(low_power_ok, 1500, "no sleep");
    pressed[75] = 1'b1;
    pressed[76] = 1'b1;
    pressed[83] = 1'b1;
    get_evt(1'b1, 9, 3);
    get_evt(1'b1, 9, 4);
    get_evt(1'b1, 10, 3);
    pressed = '0;
    get_evt(1'b0, 9, 3);
    get_evt(1'b0, 9, 4);
    get_evt(1'b0, 10, 3);
    $display("unfitted corner test done");
  endtask
  // Busy system, longer settle, unfitted key beside a real one
  task automatic t_settle();
    int k;
    wait_on(low_power_ok, 1500, "no sleep");
    sys_idle = 1'b0;
    #1;
    check(low_power_ok === 1'b0 && polling_active === 1'b0, "sleep while busy");
    settle = 8'h05;
    pressed[100] = 1'b1;
    pressed[2] = 1'b1;
    wait_on(key_wake, 10, "no wake");
    for (k = 0; k < 100 && scan_drive_line === 15'h7ffe; k++) tick();
    check(k == 5 + SYNC_LAT + 1, "row 0 settle length");
    get_evt(1'b1, 0, 2);
    check(evt_valid === 1'b0, "unfitted key reported");
    pressed = '0;
    get_evt(1'b0, 0, 2);
    $display("settle and unfitted key test done");
  endtask
  initial begin
    resetn = 1'b0;
    sys_idle = 1'b1;
    settle = 8'h01;
    pressed = '0;
    key_fitted = {{(KEY_SLOTS-FITTED_KEYS){1'b0}}, {FITTED_KEYS{1'b1}}};
    tick(2);
    check(scan_drive_line === DRIVE_ALL_ON && polling_active === 1'b0, "reset arm");
    resetn = 1'b1;
    t_single();
    t_ghost();
    t_unfit();
    t_settle();
    wrap_up();
  end
endmodule
